/* sflash_pkg.sv */
package sflash_pkg;

	// read opcodes
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FAST     = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO  = 8'heb;

	// phase lengths in bits
	localparam logic [4:0] CMD_BITS  = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] MODE_BITS = 5'h08;

	// dummy clock counts and four-line mode byte clocks
	localparam logic [3:0] FAST_DUMMY = 4'h8;
	localparam logic [3:0] QIO_DUMMY  = 4'h4;
	localparam logic [3:0] MODE_CLKS4 = 4'h2;

	// reset values and codes
	localparam logic [1:0] PARAM_RST = 2'h0;
	localparam logic [1:0] SKIP_CODE = 2'h2;

	// lane width as log2 of lines used
	localparam logic [1:0] LW1 = 2'h0;
	localparam logic [1:0] LW2 = 2'h1;
	localparam logic [1:0] LW4 = 2'h2;

	typedef struct packed {
		logic       ok;
		logic [1:0] aw;
		logic       mode;
		logic [3:0] dummy;
		logic [1:0] dw;
	} rd_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
	} rd_state_t;

endpackage

/* sflash_read_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_read_dev
	import sflash_pkg::*;
(
	// system
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	// serial link, line 0 is the serial_input_pin
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic [3:0]  i_bidir_line,
	output logic      [3:0]  o_bidir_line,
	output logic      [3:0]  o_bidir_line_oe_n,
	// status and configuration
	input  wire logic        i_busy,
	input  wire logic        i_quad_enable_bit,
	input  wire logic        i_four_line_command_mode,
	input  wire logic        i_param_wr,
	input  wire logic [1:0]  i_param_dummy,
	input  wire logic        i_reset_cmd,
	// memory array
	output logic             o_mem_rd,
	output logic      [23:0] o_mem_addr,
	input  wire logic [7:0]  i_mem_data,
	// block state
	output logic             o_data_phase,
	output logic             o_execute_in_place
);

	// command table, shared by the opcode decoder
	function automatic rd_cfg_t decode(input logic [7:0] op,
		input logic four_line_command_mode, input logic qe, input logic [3:0] pd);
		rd_cfg_t c;
		c = '0;
		c.ok = 1'b1;
		case (op)
			OP_READ: c.ok = ~four_line_command_mode;
			OP_FAST: begin
				c.aw    = four_line_command_mode ? LW4 : LW1;
				c.dw    = four_line_command_mode ? LW4 : LW1;
				c.dummy = four_line_command_mode ? pd : FAST_DUMMY;
			end
			OP_DUAL_OUT: begin
				c.ok    = ~four_line_command_mode;
				c.dw    = LW2;
				c.dummy = FAST_DUMMY;
			end
			OP_QUAD_OUT: begin
				c.ok    = ~four_line_command_mode & qe;
				c.dw    = LW4;
				c.dummy = FAST_DUMMY;
			end
			OP_DUAL_IO: begin
				c.ok   = ~four_line_command_mode;
				c.aw   = LW2;
				c.dw   = LW2;
				c.mode = 1'b1;
			end
			OP_QUAD_IO: begin
				c.ok    = qe;
				c.aw    = LW4;
				c.dw    = LW4;
				c.mode  = 1'b1;
				c.dummy = four_line_command_mode ? pd - MODE_CLKS4 : QIO_DUMMY;
			end
			default: c.ok = 1'b0;
		endcase
		return c;
	endfunction

	// shift one clock's worth of input lines into the assembler
	function automatic logic [23:0] shift_in(input logic [23:0] s,
		input logic [3:0] d, input logic [1:0] w);
		case (w)
			LW2:     return {s[21:0], d[1:0]};
			LW4:     return {s[19:0], d};
			default: return {s[22:0], d[0]};
		endcase
	endfunction

	logic [5:0]  meta_q;
	logic [5:0]  sync_q;
	logic        sclk_prev_q;
	logic        cs_prev_q;
	logic [1:0]  param_q;
	rd_state_t   state_q;
	logic [4:0]  cnt_q;
	logic [3:0]  dcnt_q;
	logic [23:0] sr_q;
	logic [23:0] start_q;
	rd_cfg_t     cfg_q;
	rd_cfg_t     crm_cfg_q;
	logic        crm_q;
	logic        in_data_q;
	logic        rd_q;
	logic        cap_q;
	logic [23:0] maddr_q;
	logic [7:0]  nxt_q;
	logic [7:0]  ob_q;
	logic [2:0]  ocnt_q;
	logic [3:0]  out_q;
	logic [3:0]  oe_n_q;

	// two-stage synchronisers for every link input; they reset to
	// the idle link (select high, clock low), so no edge follows reset
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= 6'h20;
			sync_q <= 6'h20;
		end else begin
			meta_q <= {i_cs_n, i_sclk, i_bidir_line};
			sync_q <= meta_q;
		end
	end

	// edge history of the synchronised clock and select
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_prev_q <= sync_q[4];
			cs_prev_q   <= sync_q[5];
		end
	end

	// link decoding
	wire        cs_n     = sync_q[5];
	wire [3:0]  din      = sync_q[3:0];
	wire        rise     = sync_q[4] & ~sclk_prev_q & ~cs_n;
	wire        fall     = ~sync_q[4] & sclk_prev_q & ~cs_n;
	wire        frm_go   = ~cs_n & cs_prev_q;
	wire        four_line_command_mode      = i_four_line_command_mode &
	                       i_quad_enable_bit;
	wire [3:0]  qpi_dum  = {1'b0, param_q, 1'b0} + 4'h2;
	wire [1:0]  cur_w    = (state_q == ST_CMD) ? (four_line_command_mode ? LW4 : LW1)
	                                           : cfg_q.aw;
	wire [23:0] sr_nx    = shift_in(sr_q, din, cur_w);
	wire [4:0]  cnt_nx   = cnt_q + (5'h01 << cur_w);
	wire        data_go  = (state_q == ST_DATA) & ~in_data_q;
	wire        byte_end = fall & (state_q == ST_DATA) & (ocnt_q == 3'h0);
	wire [7:0]  obyte    = (ocnt_q == 3'h0) ? nxt_q : ob_q;
	wire [3:0]  obits    = {1'b0, (3'h1 << cfg_q.dw)};
	rd_cfg_t    dec;
	assign dec = decode(sr_nx[7:0], four_line_command_mode, i_quad_enable_bit, qpi_dum);
	wire        no_dum   = (cfg_q.dummy == 4'h0);

	// read parameter for four-line mode dummy count
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst)
			param_q <= PARAM_RST;
		else if (i_reset_cmd)
			param_q <= PARAM_RST;
		else if (i_param_wr)
			param_q <= i_param_dummy;
	end

	// command sequencer, advanced on serial clock rising edges;
	// only the continuous read state outlives a frame
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q   <= ST_IDLE;
			cnt_q     <= 5'h00;
			dcnt_q    <= 4'h0;
			sr_q      <= 24'h000000;
			start_q   <= 24'h000000;
			cfg_q     <= '0;
			crm_cfg_q <= '0;
			crm_q     <= 1'b0;
		end else if (cs_n) begin
			state_q <= ST_IDLE;
		end else if (frm_go) begin
			cnt_q <= 5'h00;
			if (i_busy)
				state_q <= ST_IGNORE;
			else if (crm_q) begin
				cfg_q   <= crm_cfg_q;
				state_q <= ST_ADDR;
			end else
				state_q <= ST_CMD;
		end else if (rise) begin
			sr_q  <= sr_nx;
			cnt_q <= cnt_nx;
			dcnt_q <= dcnt_q - 4'h1;
			case (state_q)
				ST_CMD: if (cnt_nx == CMD_BITS) begin
					cnt_q   <= 5'h00;
					cfg_q   <= dec;
					state_q <= dec.ok ? ST_ADDR : ST_IGNORE;
				end
				ST_ADDR: if (cnt_nx == ADDR_BITS) begin
					cnt_q   <= 5'h00;
					start_q <= sr_nx;
					dcnt_q  <= cfg_q.dummy;
					if (cfg_q.mode)
						state_q <= ST_MODE;
					else
						state_q <= no_dum ? ST_DATA : ST_DUMMY;
				end
				ST_MODE: if (cnt_nx == MODE_BITS) begin
					// only bits 5:4 matter, low nibble is ignored
					crm_q     <= (sr_nx[5:4] == SKIP_CODE);
					crm_cfg_q <= cfg_q;
					dcnt_q    <= cfg_q.dummy;
					state_q   <= no_dum ? ST_DATA : ST_DUMMY;
				end
				ST_DUMMY: if (dcnt_q == 4'h1)
					state_q <= ST_DATA;
				default: ;
			endcase
		end
	end

	// memory fetch: first byte at data entry, then one per byte sent,
	// so the next byte waits ready well before its first falling edge
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			in_data_q <= 1'b0;
			rd_q      <= 1'b0;
			cap_q     <= 1'b0;
			maddr_q   <= 24'h000000;
			nxt_q     <= 8'h00;
		end else begin
			in_data_q <= (state_q == ST_DATA);
			cap_q     <= rd_q;
			rd_q      <= data_go | byte_end;
			if (cap_q)
				nxt_q <= i_mem_data;
			if (data_go)
				maddr_q <= start_q;
			else if (rd_q)
				maddr_q <= maddr_q + 24'h000001;
		end
	end

	// output shifter, changes on serial clock falling edges;
	// lines are released as soon as select is seen high
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ob_q   <= 8'h00;
			ocnt_q <= 3'h0;
			out_q  <= 4'h0;
			oe_n_q <= 4'hf;
		end else if (cs_n) begin
			ocnt_q <= 3'h0;
			oe_n_q <= 4'hf;
		end else if (fall && state_q == ST_DATA) begin
			ob_q   <= obyte << obits;
			ocnt_q <= ocnt_q + obits[2:0];
			case (cfg_q.dw)
				LW2: begin
					out_q  <= {2'b00, obyte[7:6]};
					oe_n_q <= 4'hc;
				end
				LW4: begin
					out_q  <= obyte[7:4];
					oe_n_q <= 4'h0;
				end
				default: begin
					out_q  <= {2'b00, obyte[7], 1'b0};
					oe_n_q <= 4'hd;
				end
			endcase
		end
	end

	// outputs
	assign o_bidir_line      = out_q;
	assign o_bidir_line_oe_n = oe_n_q;
	assign o_mem_rd          = rd_q;
	assign o_mem_addr        = maddr_q;
	assign o_data_phase      = in_data_q;
	assign o_execute_in_place = crm_q;

endmodule
`default_nettype wire

/* sflash_read_dev_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_read_dev_properties (
	// clock, frame and status
	input wire logic       i_mclk,
	input wire logic       i_sys_rst,
	input wire logic       i_cs_n,
	input wire logic       i_sclk,
	input wire logic       i_busy,
	// device outputs
	input wire logic [3:0] o_bidir_line,
	input wire logic [3:0] o_bidir_line_oe_n,
	input wire logic       o_mem_rd,
	input wire logic       o_data_phase,
	input wire logic       o_execute_in_place
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// framing and release of the lines
	chk_lines_freed: assert property ($rose(i_cs_n) |-> ##[1:8]
		o_bidir_line_oe_n == 4'hf) else $error("lines still driven");
	chk_data_end: assert property ($fell(o_data_phase) |-> ##[0:4]
		o_bidir_line_oe_n == 4'hf) else $error("lines kept after data");
	chk_skip_kept: assert property ($changed(o_execute_in_place) |->
		!i_cs_n && !$past(i_cs_n, 8)) else $error("skip state moved");
	// array reads
	chk_read_pulse: assert property (o_mem_rd |=> !o_mem_rd)
		else $error("array read too long");
	chk_read_in_data: assert property (o_mem_rd |-> o_data_phase &&
		!$past(i_cs_n, 2)) else $error("array read outside data");
	chk_busy_ignored: assert property (i_busy && $past(i_busy, 8) |->
		o_bidir_line_oe_n == 4'hf && !o_mem_rd) else $error("busy read");
	// output lanes and timing
	chk_lane_set: assert property (o_bidir_line_oe_n inside
		{4'hf, 4'hd, 4'hc, 4'h0}) else $error("bad drive set");
	chk_out_on_fall: assert property ($changed(o_bidir_line) &&
		o_bidir_line_oe_n != 4'hf |-> !$past(i_sclk) && !$past(i_sclk, 2))
		else $error("output moved off a falling edge");
endmodule
bind sflash_read_dev sflash_read_dev_properties u_chk (.*);
`default_nettype wire

/* sflash_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_host_model (
	// link pins
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic      [3:0] o_line,
	// device drive
	input  wire logic [3:0] i_dev,
	input  wire logic [3:0] i_dev_oe_n
);
	logic [3:0] hv = 4'h0;
	logic [3:0] hoe_n = 4'hf;
	// device wins, then host, else pull-up
	assign o_line = ~i_dev_oe_n & i_dev | i_dev_oe_n & (hoe_n | hv);
	initial o_cs_n = 1'b1;
	initial o_sclk = 1'b0;
	// drive n bits msb first over w lines, sampled on rise
	task automatic send(logic [31:0] x, int n, int w);
		for (int i = n; i > 0; i -= w) begin
			hoe_n = 4'hf << w;
			hv = 4'(x >> (i - w));
			#40 o_sclk = 1'b1;
			#40 o_sclk = 1'b0;
		end
	endtask
	// release lines, take n bits over w lines
	task automatic recv(input int n, w, output logic [31:0] x);
		hoe_n = 4'hf;
		x = 32'h0;
		for (int i = 0; i < n; i += w) begin
			#40 o_sclk = 1'b1;
			x = x << w | 32'((w > 1 ? o_line : o_line >> 1) & ~(4'hf << w));
			#40 o_sclk = 1'b0;
		end
	endtask
	// one frame: opcode, address, mode, dummies, two bytes
	task automatic rd(logic [7:0] op, int ow, aw, dm, dw, logic [23:0] a,
		logic [8:0] md, output logic [31:0] x);
		#100 o_cs_n = 1'b0;
		#40;
		if (ow > 0) send(32'(op), 8, ow);
		send(32'(a), 24, aw);
		if (md[8]) send(32'(md[7:0]), 8, aw);
		recv(dm, 1, x);
		recv(16, dw, x);
		#40 o_cs_n = 1'b1;
		#100;
	endtask
	// exit frame: all ones on line 0 for n clocks, then deselect
	task automatic quit(int n);
		#100 o_cs_n = 1'b0;
		#40;
		send(32'hffffffff, n, 1);
		hoe_n = 4'hf;
		#40 o_cs_n = 1'b1;
		#100;
	endtask
endmodule
`default_nettype wire

/* sflash_read_dev_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_read_dev_tb;
	import sflash_pkg::*;
	localparam logic [23:0] AD = 24'h0012ff;
	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_busy = 1'b0;
	logic        i_quad_enable_bit = 1'b1;
	logic        i_four_line_command_mode = 1'b0;
	logic        i_param_wr = 1'b0;
	logic        i_reset_cmd = 1'b0;
	logic [1:0]  i_param_dummy = 2'h0;
	logic [7:0]  i_mem_data = 8'h00;
	logic        i_cs_n, i_sclk, o_mem_rd, o_data_phase, o_execute_in_place;
	logic [3:0]  i_bidir_line, o_bidir_line, o_bidir_line_oe_n;
	logic [23:0] o_mem_addr;
	logic [31:0] v;
	int          n_fail = 0;
	int          comparisons = 0;
	sflash_read_dev u_dut (
		.i_mclk                   (i_mclk),
		.i_sys_rst                (i_sys_rst),
		.i_cs_n                   (i_cs_n),
		.i_sclk                   (i_sclk),
		.i_bidir_line             (i_bidir_line),
		.o_bidir_line             (o_bidir_line),
		.o_bidir_line_oe_n        (o_bidir_line_oe_n),
		.i_busy                   (i_busy),
		.i_quad_enable_bit        (i_quad_enable_bit),
		.i_four_line_command_mode (i_four_line_command_mode),
		.i_param_wr               (i_param_wr),
		.i_param_dummy            (i_param_dummy),
		.i_reset_cmd              (i_reset_cmd),
		.o_mem_rd                 (o_mem_rd),
		.o_mem_addr               (o_mem_addr),
		.i_mem_data               (i_mem_data),
		.o_data_phase             (o_data_phase),
		.o_execute_in_place       (o_execute_in_place)
	);
	sflash_host_model u_host (.o_cs_n(i_cs_n), .o_sclk(i_sclk),
		.o_line(i_bidir_line), .i_dev(o_bidir_line),
		.i_dev_oe_n(o_bidir_line_oe_n));
	// array content: low address byte mixed with the next one
	function automatic logic [7:0] e(logic [23:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	function automatic logic [31:0] two(logic [23:0] a);
		return {16'h0, e(a), e(a + 24'h1)};
	endfunction
	// 200 MHz clock; array answers the cycle after a read
	always #2.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		if (o_mem_rd) i_mem_data <= e(o_mem_addr);
	end
	task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, x, s);
		end
	endtask
	// single-line address reads of each output width
	task automatic t_plain;
		logic [7:0] op [4] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT};
		int         w [4] = '{1, 1, 2, 4};
		foreach (op[i]) begin
			u_host.rd(op[i], 1, 1, i > 0 ? 8 : 0, w[i], AD, 9'h0, v);
			chk("read", v, two(AD));
		end
		chk("release", 32'(o_bidir_line_oe_n), 32'hf);
	endtask
	// refused frames leave every line released
	task automatic t_refuse;
		logic [10:0] c [4] = '{{3'h6, OP_READ}, {3'h0, OP_QUAD_OUT},
			{3'h0, OP_QUAD_IO}, {3'h3, OP_READ}};
		foreach (c[i]) begin
			{i_busy, i_quad_enable_bit, i_four_line_command_mode} = c[i][10:8];
			u_host.rd(c[i][7:0], c[i][8] ? 4 : 1, 1, 8, 1, AD, 9'h0, v);
			chk("refused", v, 32'hffff);
		end
		{i_busy, i_quad_enable_bit, i_four_line_command_mode} = 3'h2;
	endtask
	// mode bits 10 arm an opcode-free frame, all ones disarm it
	task automatic t_xip;
		for (int k = 0; k < 4; k++) begin
			u_host.rd(k < 2 ? OP_DUAL_IO : OP_QUAD_IO, k % 2 ? 0 : 1,
				2 << k / 2, k < 2 ? 0 : 4, 2 << k / 2, AD,
				k % 2 ? 9'h1ff : 9'h12f, v);
			chk("skip data", v, two(AD));
			chk("skip flag", 32'(o_execute_in_place), 32'(k % 2 == 0));
		end
		// arm again, then leave by holding line 0 high through the frame
		for (int k = 0; k < 2; k++) begin
			u_host.rd(k ? OP_QUAD_IO : OP_DUAL_IO, 1, 2 << k, 4 * k,
				2 << k, AD, 9'h12f, v);
			chk("skip armed", 32'(o_execute_in_place), 32'h1);
			u_host.quit(16 >> k);
			chk("skip exit", 32'(o_execute_in_place), 32'h0);
		end
	endtask
	// four-line fast read for each dummy setting, then after reset
	task automatic t_qpi;
		i_four_line_command_mode = 1'b1;
		for (int i = 0; i < 5; i++) begin
			{i_reset_cmd, i_param_wr, i_param_dummy} = {i == 4, i < 4, 2'(i)};
			#5 {i_reset_cmd, i_param_wr} = 2'h0;
			u_host.rd(OP_FAST, 4, 4, i < 4 ? 2 * i + 2 : 2, 4, AD, 9'h0, v);
			chk("four line", v, two(AD));
		end
		// four-line quad io: the mode byte uses up both default dummies
		u_host.rd(OP_QUAD_IO, 4, 4, 0, 4, AD, 9'h100, v);
		chk("four line quad io", v, two(AD));
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
	initial begin
		#15 i_sys_rst = 1'b0;
		t_plain();
		t_refuse();
		t_xip();
		t_qpi();
		give_verdict();
	end
endmodule
`default_nettype wire
